// File: hw/pwm_ctl_pkg.sv
// Contract
// [RULE1] primary dead time is 14 bits, bits 15-14 read zero
// [RULE2] separate 14-bit alternate dead time for the dead-time unit
// [RULE3] divider n emits one trigger per n+1 compare events
// [RULE4] first trigger waits the 6-bit count of pwm cycles after enable
// [RULE5] ownership bits pick pwm or gpio per pin, both reset to one
// [RULE6] polarity bit set makes that output active-low
// [RULE7] 2-bit pair mode: complementary, redundant, push-pull; 11 reserved
// [RULE8] override enables put override data bits on the high and low pins
// [RULE9] active fault in enabled mode forces fault data onto both pins
// [RULE10] active enabled current limit forces limit data onto both pins
// [RULE11] swap bit exchanges the high and low signals between pins
// [RULE12] override sync set applies overrides on time base, else immediately
// [RULE13] sync point is count zero edge-aligned, phase match center-aligned; code matches phase only with i_independent_tb set, else count zero
// [RULE14] software sets override sync before changing swap
// [RULE15] software leaves pair mode alone once the module is enabled
// [RULE16] with lock config set, control writes need the unlock sequence
// [RULE17] local time base equal to trigger compare raises an adc trigger; code compares only with i_independent_tb set and the module enabled
// [RULE18] 5-bit limit source: faults 1-4, comparators 1-4, rest reserved
// [RULE19] limit polarity set means active-low; limit mode enables limit action
// [RULE20] fault mode: 00 latched, 01 cycle, 11 disabled, 10 reserved
// [RULE21] phase register holds phase shift, or period in independent mode
// constants and types for the pwm output-stage control block
// assumes an axi4-lite master on the same clock
package pwm_ctl_pkg;
   localparam logic [5:0] ADDR_DEAD = 6'h00;
   localparam logic [5:0] ADDR_ALTDEAD = 6'h04;
   localparam logic [5:0] ADDR_TRGCTL = 6'h08;
   localparam logic [5:0] ADDR_PINCTL = 6'h0C;
   localparam logic [5:0] ADDR_TRIGGER_COMPARE = 6'h10;
   localparam logic [5:0] ADDR_FLTCTL = 6'h14;
   localparam logic [5:0] ADDR_PHASE = 6'h18;
   localparam logic [5:0] ADDR_UNLOCK = 6'h1C;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
   localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;
   localparam logic [15:0] DEAD_MASK = 16'h3FFF;
   localparam logic [15:0] TRGCTL_MASK = 16'hF03F;
   localparam logic [15:0] FLTCTL_MASK = 16'h7FFF;
   localparam logic [15:0] PINCTL_RESET = 16'hC000;
   localparam logic [15:0] FLTCTL_RESET = 16'h00F8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MODE_COMP = 2'b00, MODE_REDUN = 2'b01, MODE_PUSH = 2'b10, MODE_RSVD = 2'b11} pair_mode_t;
   typedef enum logic [1:0] {FLT_LATCH = 2'b00, FLT_CYCLE = 2'b01, FLT_RSVD = 2'b10, FLT_OFF = 2'b11} fault_mode_t;
   typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_KEY1 = 2'b01, LK_OPEN = 2'b10} lock_state_t;
   typedef struct packed {
      logic high_pin_owner;
      logic low_pin_owner;
      logic high_pin_polarity;
      logic low_pin_polarity;
      pair_mode_t pair_output_mode;
      logic high_override_enable;
      logic low_override_enable;
      logic [1:0] override_data;
      logic [1:0] fault_pin_data;
      logic [1:0] limit_pin_data;
      logic swap;
      logic override_sync;
   } pin_ctl_t;
   typedef struct packed {
      logic rsvd;
      logic [4:0] limit_source_select;
      logic limit_polarity;
      logic limit_mode_enable;
      logic [4:0] fault_source_select;
      logic fault_polarity;
      fault_mode_t fault_action_mode;
   } flt_ctl_t;
   typedef struct packed {
      logic high;
      logic low;
   } pin_pair_t;
endpackage

// File: hw/pwm_output_deadtime_trigger_ctl.sv
// pwm generator output stage, dead-time and trigger configuration
// time base, fault/limit inputs come from logic on i_clk; sources are synchronised here
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module pwm_output_deadtime_trigger_ctl
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [5:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [5:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_write_lock_config,
   input wire logic i_module_enable,
   input wire logic i_center_aligned,
   input wire logic i_independent_tb,
   input wire logic [15:0] i_time_base,
   input wire logic i_pwm_cycle_start,
   input wire logic [3:0] i_fault_in,
   input wire logic [3:0] i_cmp_in,
   input wire pwm_ctl_pkg::pin_pair_t i_gen_out,
   input wire pwm_ctl_pkg::pin_pair_t i_gpio_out,
   output pwm_ctl_pkg::pin_pair_t o_pin,
   output logic o_adc_trigger,
   output logic [13:0] o_dead_time_value,
   output logic [13:0] o_alternate_dead_time_value,
   output logic [15:0] o_phase_or_period
);
   import pwm_ctl_pkg::*;

   logic [13:0] dead_ff;
   logic [13:0] altdead_ff;
   logic [3:0] trigger_divider_ff;
   logic [5:0] first_trigger_wait_ff;
   pin_ctl_t pinctl_ff;
   logic [15:0] trigger_compare_ff;
   flt_ctl_t fltctl_ff;
   logic [15:0] phase_ff;
   lock_state_t lock_ff;
   logic aw_ff, w_ff;
   logic [5:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] ovr_active_ff;
   logic [1:0] ovr_data_ff;
   logic [7:0] src_s1_ff, src_s2_ff;
   logic fault_latch_ff;
   logic [3:0] div_cnt_ff;
   logic [5:0] wait_cnt_ff;
   logic en_d_ff;
   logic do_write, wr_ok, ctl_locked;
   logic [15:0] wd, rd_val;
   logic fault_src, limit_src, fault_act, limit_act, sync_pt, cmp_hit;
   pin_pair_t gen_sw, ovr_in, drv;

   // merge 16-bit write data under byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // pick one source of the eight documented codes
   function automatic logic pick_src(input logic [4:0] sel, input logic [7:0] src, input logic pol);
      logic v;
      v = 1'b0;
      if (sel[4:2] == 3'b000)
         v = src[{1'b0, sel[1:0]}];
      else if (sel[4:2] == 3'b010)
         v = src[{1'b1, sel[1:0]}];
      pick_src = ((sel[4:2] == 3'b000) || (sel[4:2] == 3'b010)) ? (v ^ pol) : 1'b0;
   endfunction

   // axi4-lite write path
   assign do_write = aw_ff && w_ff && !o_bvalid;
   assign wd = merge16(16'h0000, wdata_ff, wstrb_ff);
   assign ctl_locked = i_write_lock_config && (lock_ff != LK_OPEN); // see [RULE16]

   always_comb
   begin
      wr_ok = 1'b1;
      case (awaddr_ff)
         ADDR_DEAD, ADDR_ALTDEAD, ADDR_TRGCTL, ADDR_TRIGGER_COMPARE, ADDR_PHASE, ADDR_UNLOCK, ADDR_STATUS: wr_ok = 1'b1;
         ADDR_PINCTL, ADDR_FLTCTL: wr_ok = !ctl_locked; // see [RULE16]
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 6'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
      end
      else if (i_ce)
      begin
         o_awready <= !aw_ff && !o_awready && i_awvalid;
         o_wready <= !w_ff && !o_wready && i_wvalid;
         if (i_awvalid && o_awready)
         begin
            aw_ff <= 1'b1;
            awaddr_ff <= {i_awaddr[5:2], 2'b00};
         end
         if (i_wvalid && o_wready)
         begin
            w_ff <= 1'b1;
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (do_write)
         begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
         end
      end
   end

   // register storage
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         dead_ff <= 14'h0000;
         altdead_ff <= 14'h0000;
         trigger_divider_ff <= 4'h0;
         first_trigger_wait_ff <= 6'h00;
         pinctl_ff <= PINCTL_RESET;
         trigger_compare_ff <= 16'h0000;
         fltctl_ff <= FLTCTL_RESET;
         phase_ff <= 16'h0000;
         lock_ff <= LK_IDLE;
      end
      else if (i_ce && do_write && wr_ok)
      begin
         case (awaddr_ff)
            ADDR_DEAD: dead_ff <= 14'(merge16({2'b00, dead_ff}, wdata_ff, wstrb_ff)); // see [RULE1]
            ADDR_ALTDEAD: altdead_ff <= 14'(merge16({2'b00, altdead_ff}, wdata_ff, wstrb_ff)); // see [RULE2]
            ADDR_TRGCTL:
            begin
               if (wstrb_ff[1])
                  trigger_divider_ff <= wdata_ff[15:12];
               if (wstrb_ff[0])
                  first_trigger_wait_ff <= wdata_ff[5:0];
            end
            ADDR_PINCTL: pinctl_ff <= merge16(pinctl_ff, wdata_ff, wstrb_ff); // see [RULE5]
            ADDR_TRIGGER_COMPARE: trigger_compare_ff <= merge16(trigger_compare_ff, wdata_ff, wstrb_ff);
            ADDR_FLTCTL: fltctl_ff <= merge16(fltctl_ff, wdata_ff, wstrb_ff) & FLTCTL_MASK;
            ADDR_PHASE: phase_ff <= merge16(phase_ff, wdata_ff, wstrb_ff); // see [RULE21]
            ADDR_UNLOCK:
            begin
               // two-key sequence opens one locked control write
               if (lock_ff == LK_IDLE && wd == UNLOCK_KEY1)
                  lock_ff <= LK_KEY1;
               else if (lock_ff == LK_KEY1 && wd == UNLOCK_KEY2)
                  lock_ff <= LK_OPEN; // see [RULE16]
               else
                  lock_ff <= LK_IDLE;
            end
            default: lock_ff <= lock_ff;
         endcase
         if (awaddr_ff == ADDR_PINCTL || awaddr_ff == ADDR_FLTCTL)
            lock_ff <= LK_IDLE;
      end
   end

   // axi4-lite read path
   always_comb
   begin
      rd_val = 16'h0000;
      case ({i_araddr[5:2], 2'b00})
         ADDR_DEAD: rd_val = {2'b00, dead_ff}; // see [RULE1]
         ADDR_ALTDEAD: rd_val = {2'b00, altdead_ff};
         ADDR_TRGCTL: rd_val = {trigger_divider_ff, 6'h00, first_trigger_wait_ff} & TRGCTL_MASK;
         ADDR_PINCTL: rd_val = pinctl_ff;
         ADDR_TRIGGER_COMPARE: rd_val = trigger_compare_ff;
         ADDR_FLTCTL: rd_val = fltctl_ff;
         ADDR_PHASE: rd_val = phase_ff;
         ADDR_UNLOCK: rd_val = {14'h0000, lock_ff};
         ADDR_STATUS: rd_val = {11'h000, limit_act, fault_act, fault_latch_ff, ovr_active_ff};
         default: rd_val = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= 2'h0;
      end
      else if (i_ce)
      begin
         o_arready <= !o_arready && !o_rvalid && i_arvalid;
         if (i_arvalid && o_arready)
         begin
            o_rvalid <= 1'b1;
            o_rdata <= {16'h0000, rd_val};
            o_rresp <= (i_araddr[5:2] > ADDR_STATUS[5:2]) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
      end
   end

   // source synchronisers and protection
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         src_s1_ff <= 8'h00;
         src_s2_ff <= 8'h00;
      end
      else if (i_ce)
      begin
         src_s1_ff <= {i_cmp_in, i_fault_in};
         src_s2_ff <= src_s1_ff;
      end
   end

   assign fault_src = pick_src(fltctl_ff.fault_source_select, src_s2_ff, fltctl_ff.fault_polarity);
   assign limit_src = pick_src(fltctl_ff.limit_source_select, src_s2_ff, fltctl_ff.limit_polarity); // see [RULE18] [RULE19]
   assign limit_act = limit_src && fltctl_ff.limit_mode_enable; // see [RULE19]
   assign fault_act = (fltctl_ff.fault_action_mode == FLT_CYCLE) ? fault_src :
                      (fltctl_ff.fault_action_mode == FLT_LATCH) ? (fault_src || fault_latch_ff) : 1'b0; // see [RULE20]

   // latched fault clears at a cycle start once the source is gone
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         fault_latch_ff <= 1'b0;
      else if (i_ce)
      begin
         if (fault_src && fltctl_ff.fault_action_mode == FLT_LATCH)
            fault_latch_ff <= 1'b1; // see [RULE20]
         else if (i_pwm_cycle_start || fltctl_ff.fault_action_mode != FLT_LATCH)
            fault_latch_ff <= 1'b0;
      end
   end

   // override apply point
   assign sync_pt = (i_center_aligned && i_independent_tb) ? (i_time_base == phase_ff) : (i_time_base == 16'h0000); // see [RULE13]

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ovr_active_ff <= 2'b00;
         ovr_data_ff <= 2'b00;
      end
      else if (i_ce && (!pinctl_ff.override_sync || sync_pt))
      begin
         ovr_active_ff <= {pinctl_ff.high_override_enable, pinctl_ff.low_override_enable}; // see [RULE12]
         ovr_data_ff <= pinctl_ff.override_data; // see [RULE12]
      end
   end

   // output mux: swap, override, limit, fault, polarity, owner
   always_comb
   begin
      gen_sw = i_gen_out;
      if (pinctl_ff.swap)
      begin
         gen_sw.high = i_gen_out.low; // see [RULE11]
         gen_sw.low = i_gen_out.high;
      end
      case (pinctl_ff.pair_output_mode) // see [RULE7]
         MODE_COMP: gen_sw.low = !gen_sw.high;
         MODE_REDUN: gen_sw.low = gen_sw.high;
         default: gen_sw.low = gen_sw.low;
      endcase
      drv.high = ovr_active_ff[1] ? ovr_data_ff[1] : gen_sw.high; // see [RULE8]
      drv.low = ovr_active_ff[0] ? ovr_data_ff[0] : gen_sw.low;
      if (limit_act)
         drv = '{high: pinctl_ff.limit_pin_data[1], low: pinctl_ff.limit_pin_data[0]}; // see [RULE10]
      if (fault_act)
         drv = '{high: pinctl_ff.fault_pin_data[1], low: pinctl_ff.fault_pin_data[0]}; // see [RULE9]
      drv.high = drv.high ^ pinctl_ff.high_pin_polarity; // see [RULE6]
      drv.low = drv.low ^ pinctl_ff.low_pin_polarity;
      ovr_in.high = pinctl_ff.high_pin_owner ? drv.high : i_gpio_out.high; // see [RULE5]
      ovr_in.low = pinctl_ff.low_pin_owner ? drv.low : i_gpio_out.low;
   end

   // trigger compare, start wait and divider
   assign cmp_hit = i_module_enable && i_independent_tb && (i_time_base == trigger_compare_ff); // see [RULE17]

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         en_d_ff <= 1'b0;
         wait_cnt_ff <= 6'h00;
         div_cnt_ff <= 4'h0;
         o_adc_trigger <= 1'b0;
      end
      else if (i_ce)
      begin
         en_d_ff <= i_module_enable;
         o_adc_trigger <= 1'b0;
         if (i_module_enable && !en_d_ff)
         begin
            wait_cnt_ff <= first_trigger_wait_ff; // see [RULE4]
            div_cnt_ff <= 4'h0;
         end
         else if (wait_cnt_ff != 6'h00)
         begin
            if (i_pwm_cycle_start)
               wait_cnt_ff <= wait_cnt_ff - 6'h01; // see [RULE4]
         end
         else if (cmp_hit)
         begin
            if (div_cnt_ff >= trigger_divider_ff)
            begin
               div_cnt_ff <= 4'h0;
               o_adc_trigger <= 1'b1; // see [RULE3]
            end
            else
               div_cnt_ff <= div_cnt_ff + 4'h1;
         end
      end
   end

   // registered outputs
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pin <= 2'b00;
         o_dead_time_value <= 14'h0000;
         o_alternate_dead_time_value <= 14'h0000;
         o_phase_or_period <= 16'h0000;
      end
      else if (i_ce)
      begin
         o_pin <= ovr_in;
         o_dead_time_value <= dead_ff;
         o_alternate_dead_time_value <= altdead_ff;
         o_phase_or_period <= phase_ff;
      end
   end

   fault_forces_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && fault_act && pinctl_ff.high_pin_owner |=> o_pin.high == ($past(pinctl_ff.fault_pin_data[1]) ^ $past(pinctl_ff.high_pin_polarity)))
      else $error("fault data not on high pin"); // see [RULE9]
   limit_forces_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && limit_act && !fault_act && pinctl_ff.low_pin_owner |=> o_pin.low == ($past(pinctl_ff.limit_pin_data[0]) ^ $past(pinctl_ff.low_pin_polarity)))
      else $error("limit data not on low pin"); // see [RULE10]
   gpio_owner_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && !pinctl_ff.high_pin_owner |=> o_pin.high == $past(i_gpio_out.high))
      else $error("gpio not on high pin"); // see [RULE5]
   trig_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_adc_trigger |-> $past(cmp_hit) && $past(div_cnt_ff) >= $past(trigger_divider_ff))
      else $error("trigger without compare"); // see [RULE3] [RULE17]
   trig_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      wait_cnt_ff != 6'h00 |=> !o_adc_trigger)
      else $error("trigger during start wait"); // see [RULE4]
   lock_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && do_write && ctl_locked && awaddr_ff == ADDR_PINCTL |=> $stable(pinctl_ff) && o_bresp == RESP_SLVERR)
      else $error("locked control written"); // see [RULE16]
   ovr_sync_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && pinctl_ff.override_sync && !sync_pt |=> $stable(ovr_active_ff) && $stable(ovr_data_ff))
      else $error("override changed off sync point"); // see [RULE12] [RULE13]
   dead_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_rvalid |-> o_rdata[31:14] == 18'h00000 || $past(i_araddr[5:2]) != 4'h0)
      else $error("dead time upper bits nonzero"); // see [RULE1]
   comp_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_ce && pinctl_ff.pair_output_mode == MODE_COMP && !fault_act && !limit_act && ovr_active_ff == 2'b00
      && pinctl_ff.high_pin_owner && pinctl_ff.low_pin_owner |=> (o_pin.high ^ $past(pinctl_ff.high_pin_polarity)) !=
      (o_pin.low ^ $past(pinctl_ff.low_pin_polarity)))
      else $error("complementary pair not opposite"); // see [RULE7] [RULE11]
   trig_c: cover property (@(posedge i_clk) o_adc_trigger);
   fault_c: cover property (@(posedge i_clk) fault_act && i_ce);
   write_c: cover property (@(posedge i_clk) o_bvalid && i_bready);
endmodule

// File: test/gate_drive_model.sv
// gate driver pair and adc trigger input seen by the output stage
// assumes pins and trigger pulse are registered on i_clk
`timescale 1ns/100ps
module gate_drive_model
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire pwm_ctl_pkg::pin_pair_t i_pin,
   input wire logic i_trigger,
   output logic [7:0] o_trigger_count,
   output logic o_shoot_through
);
   import pwm_ctl_pkg::*;
   // adc start events, one per pulse
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_trigger_count <= 8'h00;
      else if (i_trigger)
         o_trigger_count <= o_trigger_count + 8'h01;
   end
   assign o_shoot_through = i_pin.high & i_pin.low;
endmodule

// File: test/test_pwm_output_deadtime_trigger_ctl.sv
// self-checking bench for the pwm output stage control block
// assumes the design package and the gate driver model compile first
`timescale 1ns/100ps
module test_pwm_output_deadtime_trigger_ctl;
   import pwm_ctl_pkg::*;
   logic clk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, lock, mod_en, center, indep, cyc_start, adc_trig, shoot;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, fault_in, cmp_in;
   logic [1:0] bresp, rresp;
   logic [15:0] time_base, phase;
   logic [13:0] dead, alt_dead;
   logic [7:0] trig_count, n0;
   pin_pair_t gen_out, gpio_out, pin;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;

   pwm_output_deadtime_trigger_ctl pwm_output_deadtime_trigger_ctl_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
      .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
      .o_rdata(rdata), .o_rresp(rresp), .i_write_lock_config(lock), .i_module_enable(mod_en),
      .i_center_aligned(center), .i_independent_tb(indep), .i_time_base(time_base),
      .i_pwm_cycle_start(cyc_start), .i_fault_in(fault_in), .i_cmp_in(cmp_in), .i_gen_out(gen_out),
      .i_gpio_out(gpio_out), .o_pin(pin), .o_adc_trigger(adc_trig), .o_dead_time_value(dead),
      .o_alternate_dead_time_value(alt_dead), .o_phase_or_period(phase));
   gate_drive_model gate_drive_model_inst (.i_clk(clk), .i_rst_b(rst_b), .i_pin(pin), .i_trigger(adc_trig),
      .o_trigger_count(trig_count), .o_shoot_through(shoot));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      check("rdata", {16'h0, e}, rdata);
      check("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk);
   endtask

   task automatic pin_is(input logic [1:0] e);
      repeat (5) @(posedge clk);
      check("pin", {30'h0, e}, {30'h0, pin});
   endtask

   // one pwm cycle is ten clocks, time base 0..9
   task automatic run(input int periods);
      for (int p = 0; p < periods; p++)
         for (int t = 0; t < 10; t++)
         begin
            @(posedge clk);
            time_base <= 16'(t);
            cyc_start <= (t == 0);
         end
      @(posedge clk);
      cyc_start <= 1'b0;
      time_base <= 16'h0000;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_regs;
      rd(ADDR_PINCTL, PINCTL_RESET, RESP_OKAY);
      rd(ADDR_FLTCTL, FLTCTL_RESET, RESP_OKAY);
      wr(ADDR_DEAD, 16'hFFFF, RESP_OKAY);
      rd(ADDR_DEAD, DEAD_MASK, RESP_OKAY);
      check("dead", 32'h3FFF, {18'h0, dead});
      wr(ADDR_ALTDEAD, 16'hD234, RESP_OKAY);
      rd(ADDR_ALTDEAD, 16'h1234, RESP_OKAY);
      check("alt_dead", 32'h1234, {18'h0, alt_dead});
      wr(ADDR_PHASE, 16'hA5A5, RESP_OKAY);
      check("phase", 32'hA5A5, {16'h0, phase});
      rd(6'h24, 16'h0000, RESP_SLVERR);
      wr(6'h28, 16'h1111, RESP_SLVERR);
   endtask

   task automatic t_pins;
      wr(ADDR_PINCTL, 16'h0000, RESP_OKAY);
      pin_is(2'b01);
      wr(ADDR_PINCTL, 16'hC000, RESP_OKAY);
      pin_is(2'b10);
      wr(ADDR_PINCTL, 16'hC400, RESP_OKAY);
      pin_is(2'b11);
      wr(ADDR_PINCTL, 16'hC800, RESP_OKAY);
      gen_out <= 2'b01;
      pin_is(2'b01);
      gen_out <= 2'b10;
      wr(ADDR_PINCTL, 16'hF000, RESP_OKAY);
      pin_is(2'b01);
      wr(ADDR_PINCTL, 16'hC001, RESP_OKAY);
      wr(ADDR_PINCTL, 16'hC003, RESP_OKAY);
      pin_is(2'b01);
      time_base <= 16'h0005;
      wr(ADDR_PINCTL, 16'hC340, RESP_OKAY);
      pin_is(2'b01);
      wr(ADDR_PINCTL, 16'hC3C1, RESP_OKAY);
      pin_is(2'b01);
      time_base <= 16'h0000;
      pin_is(2'b11);
   endtask

   task automatic t_fault;
      wr(ADDR_PINCTL, 16'hC014, RESP_OKAY);
      wr(ADDR_FLTCTL, 16'h0001, RESP_OKAY);
      fault_in <= 4'h1;
      pin_is(2'b01);
      wr(ADDR_FLTCTL, 16'h0003, RESP_OKAY);
      pin_is(2'b10);
      wr(ADDR_FLTCTL, 16'h0000, RESP_OKAY);
      fault_in <= 4'h0;
      pin_is(2'b01);
      cyc_start <= 1'b1;
      @(posedge clk);
      cyc_start <= 1'b0;
      pin_is(2'b10);
      wr(ADDR_FLTCTL, 16'h2103, RESP_OKAY);
      cmp_in <= 4'h1;
      pin_is(2'b01);
      wr(ADDR_FLTCTL, 16'h2303, RESP_OKAY);
      pin_is(2'b10);
      wr(ADDR_FLTCTL, 16'h2003, RESP_OKAY);
      pin_is(2'b10);
      wr(ADDR_FLTCTL, 16'h2D03, RESP_OKAY);
      cmp_in <= 4'h8;
      pin_is(2'b01);
      wr(ADDR_FLTCTL, 16'h0103, RESP_OKAY);
      cmp_in <= 4'h0;
      fault_in <= 4'h1;
      pin_is(2'b01);
      fault_in <= 4'h0;
   endtask

   task automatic t_lock;
      lock <= 1'b1;
      wr(ADDR_PINCTL, 16'hC000, RESP_SLVERR);
      rd(ADDR_PINCTL, 16'hC014, RESP_OKAY);
      wr(ADDR_UNLOCK, UNLOCK_KEY1, RESP_OKAY);
      wr(ADDR_UNLOCK, UNLOCK_KEY2, RESP_OKAY);
      wr(ADDR_PINCTL, 16'hC400, RESP_OKAY);
      wr(ADDR_FLTCTL, 16'h0003, RESP_SLVERR);
      wr(ADDR_DEAD, 16'h0010, RESP_OKAY);
      lock <= 1'b0;
   endtask

   task automatic trig(input logic [15:0] cmp, input logic [15:0] ctl, input int periods, input int e);
      // trigger settings change while disabled; the enable edge restarts the start wait and divider
      mod_en <= 1'b0;
      wr(ADDR_TRIGGER_COMPARE, cmp, RESP_OKAY);
      wr(ADDR_TRGCTL, ctl, RESP_OKAY);
      mod_en <= 1'b1;
      n0 = trig_count;
      run(periods);
      check("triggers", 32'(e), {24'h0, trig_count - n0});
   endtask

   initial
   begin
      rst_b = 1'b0;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, lock, mod_en, center, cyc_start} = '0;
      indep = 1'b1;
      awaddr = 6'h00;
      araddr = 6'h00;
      wdata = 32'h0;
      wstrb = 4'h3;
      time_base = 16'h0000;
      fault_in = 4'h0;
      cmp_in = 4'h0;
      gen_out = 2'b10;
      gpio_out = 2'b01;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_regs();
      t_pins();
      t_fault();
      t_lock();
      trig(16'h0005, 16'h0000, 4, 4);
      trig(16'h0020, 16'h0000, 4, 0);
      trig(16'h0005, 16'h3000, 8, 2);
      trig(16'h0005, 16'hF000, 32, 2);
      // enable lands just before the first cycle start, which counts as one waited cycle
      trig(16'h0005, 16'h0002, 5, 4);
      complete_run();
   end
endmodule
